// *** common/accel_pkg.sv ***
/*
 * Shared constants and types for the task sequencer core.
 * Assumes a single 50 MHz system clock shared with the main processor.
 */
package accel_pkg;

    localparam int          NUM_TASKS      = 8;
    localparam int          TASK_IDX_W     = 3;
    localparam int          PC_W           = 16;
    localparam int          AUX_W          = 16;
    localparam int          DATA_W         = 32;
    localparam int          TRIG_SEL_W     = 8;
    localparam int          PIPE_STAGES    = 8;
    localparam int          NUM_RESULT     = 4;
    localparam int          NUM_AUX        = 2;

    // Register offsets (word index on the plain register port)
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h01;
    localparam logic [7:0]  OFS_SW_TRIG    = 8'h02;
    localparam logic [7:0]  OFS_PC         = 8'h03;
    localparam logic [7:0]  OFS_FLT_STAT   = 8'h04;
    localparam logic [7:0]  OFS_MEM_MAP    = 8'h05;
    localparam logic [7:0]  OFS_VECT_BASE  = 8'h10;
    localparam logic [7:0]  OFS_TSEL_BASE  = 8'h18;
    localparam logic [7:0]  OFS_RES_BASE   = 8'h20;
    localparam logic [7:0]  OFS_AUX_BASE   = 8'h24;

    // Field positions
    localparam int          CTRL_BG_EN_BIT = 0;
    localparam int          CTRL_RUN_BIT   = 1;

    // Reset values
    localparam logic [PC_W-1:0]   VECT_RST = 16'h0000;
    localparam logic [TRIG_SEL_W-1:0] TSEL_RST = 8'h00;
    localparam logic [DATA_W-1:0] MEM_MAP_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_RUN   = 2'b10,
        ST_DONE  = 2'b11
    } seq_state_t;

endpackage

// *** rtl/accel_fetch_pipe.sv ***
/*
 * Instruction fetch pipeline: tracks fetch progress through the stages.
 * Assumes program memory answers on the program data bus next cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module accel_fetch_pipe
    import accel_pkg::*;
#(
    parameter int STAGES = PIPE_STAGES
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // Control
    input  wire logic              flush,
    input  wire logic              issue,
    // Status
    output logic                   busy
);

    logic [STAGES-1:0] valid_r;

    // Eight-stage shift of in-flight instructions
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            valid_r <= '0;
        else if (flush)
            valid_r <= '0;
        else
            valid_r <= {valid_r[STAGES-2:0], issue};
    end

    assign busy = |valid_r;

endmodule // accel_fetch_pipe

`default_nettype wire

// *** rtl/accel_task_sequencer_core.sv ***
/*
 * Task sequencer core of the control law accelerator.
 * Assumes triggers, end-of-task and software starts are synchronous
 * one-cycle pulses on the system clock; registers on a plain port.
 */
// The address-and-strobe port and the register offsets were decided locally.
// Overview of operation
// - Runs on system clock, no own domain
// - Eight tasks, or seven plus background
// - Launch loads PC from task vector
// - One task at a time, no nesting
// - Per-task done interrupt pulse on foreground task completion
// - Next highest-priority pending task starts automatically
// - Background task runs while foreground tasks trigger
// - Config bit makes task 8 background
// - Per-task trigger select among 256 sources
// - Sixteen-bit program counter for fetch
// - Four 32-bit results plus float status
// - Two 16-bit auxiliary address registers
// - Independent eight-stage pipeline
// - Separate program, read and write buses
// - Float math, parallel ops, branch, load/store; this core has only the float status register
// - Two CPU and two DMA message memories; none are present in this core
// - Memory blocks mapped to CPU or accelerator
// - Task size limited only by program memory
`timescale 1ns/1ps
`default_nettype none

module accel_task_sequencer_core
    import accel_pkg::*;
#(
    parameter int N_TASKS  = NUM_TASKS,
    parameter int N_SRC    = 256
)
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic [DATA_W-1:0]          reg_rdata,
    // Peripheral trigger sources
    input  wire logic [N_SRC-1:0]      periph_trig,
    // Software trigger from the main processor
    input  wire logic                  sw_trig_valid,
    input  wire logic [N_TASKS-1:0]    sw_trig_mask,
    // Execution unit handshake
    input  wire logic                  task_end,
    input  wire logic                  exec_issue,
    // Program bus
    output logic [PC_W-1:0]            program_address_bus,
    input  wire logic [DATA_W-1:0]     program_data_bus,
    // Data read and write buses
    output logic [PC_W-1:0]            read_address_bus,
    input  wire logic [DATA_W-1:0]     read_data_bus,
    output logic [PC_W-1:0]            write_address_bus,
    output logic [DATA_W-1:0]          write_data_bus,
    // Execution results loaded by the datapath
    input  wire logic                  res_we,
    input  wire logic [1:0]            res_sel,
    input  wire logic [DATA_W-1:0]     res_data,
    // Task completion interrupts
    output logic [N_TASKS-1:0]         task_done_irq,
    // Memory block ownership and status
    output logic [DATA_W-1:0]          mem_owner_map,
    output logic                       task_running,
    output logic [TASK_IDX_W-1:0]      active_task,
    output logic                       pipe_busy
);

    seq_state_t                 state_r;
    logic [N_TASKS-1:0]         pend_r;
    logic [N_TASKS-1:0]         trig_hit;
    logic [PC_W-1:0]            vect_r   [N_TASKS];
    logic [TRIG_SEL_W-1:0]      tsel_r   [N_TASKS];
    logic [DATA_W-1:0]          res_r    [NUM_RESULT];
    logic [AUX_W-1:0]           aux_r    [NUM_AUX];
    logic [DATA_W-1:0]          fstat_r;
    logic [PC_W-1:0]            pc_r;
    logic [TASK_IDX_W-1:0]      cur_r;
    logic                       bg_en_r;
    logic                       run_en_r;
    logic                       bg_active_r;
    logic [N_TASKS-1:0]         fg_mask;
    logic                       any_pend;
    logic [TASK_IDX_W-1:0]      pick;
    logic [N_TASKS-1:0]         start_pulse;
    logic                       wr_ctrl;

    // Lowest set bit wins
    function automatic logic [TASK_IDX_W-1:0] prio_enc(input logic [N_TASKS-1:0] v);
        logic [TASK_IDX_W-1:0] r;
        r = '0;
        for (int i = N_TASKS-1; i >= 0; i--)
            if (v[i])
                r = TASK_IDX_W'(i);
        return r;
    endfunction

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] b, input int n);
        return (a >= b) && (a < b + 8'(n));
    endfunction

    // Task 8 excluded from peripheral triggering and from the pending pick when background mode is set
    always_comb
    begin
        fg_mask = '1;
        if (bg_en_r)
            fg_mask[N_TASKS-1] = 1'b0;
    end

    // Trigger select per task
    genvar g;
    generate
        for (g = 0; g < N_TASKS; g++)
        begin : g_trig
            assign trig_hit[g] = (periph_trig[tsel_r[g]] && fg_mask[g])
                               || (sw_trig_valid && sw_trig_mask[g]);
        end
    endgenerate

    assign any_pend = |(pend_r & fg_mask);
    assign pick     = prio_enc(pend_r & fg_mask);
    assign wr_ctrl  = reg_write && (reg_addr == OFS_CTRL);

    always_comb
    begin
        start_pulse = '0;
        if (state_r == ST_LOAD)
            start_pulse[cur_r] = 1'b1;
    end

    // Pending flags: set wins over clear at launch
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pend_r <= '0;
        else
            pend_r <= (pend_r & ~start_pulse) | trig_hit;
    end

    // Sequencer state machine
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r     <= ST_IDLE;
            cur_r       <= '0;
            bg_active_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (run_en_r && any_pend)
                    begin
                        cur_r       <= pick;
                        bg_active_r <= 1'b0;
                        state_r     <= ST_LOAD;
                    end
                    else if (run_en_r && bg_en_r)
                    begin
                        cur_r       <= TASK_IDX_W'(N_TASKS-1);
                        bg_active_r <= 1'b1;
                        state_r     <= ST_LOAD;
                    end
                ST_LOAD:
                    state_r <= ST_RUN;
                ST_RUN:
                    if (task_end)
                        state_r <= ST_DONE;
                ST_DONE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Program counter loaded from the task vector
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pc_r <= '0;
        else if (state_r == ST_LOAD)
            pc_r <= vect_r[cur_r];
        else if (state_r == ST_RUN && exec_issue && !task_end)
            pc_r <= pc_r + PC_W'(1);
    end

    // Completion interrupt, one pulse per foreground task
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            task_done_irq <= '0;
        else
        begin
            task_done_irq <= '0;
            if (state_r == ST_RUN && task_end && !bg_active_r)
                task_done_irq[cur_r] <= 1'b1;
        end
    end

    // Control and configuration registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bg_en_r       <= 1'b0;
            run_en_r      <= 1'b0;
            mem_owner_map <= MEM_MAP_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                bg_en_r  <= reg_wdata[CTRL_BG_EN_BIT];
                run_en_r <= reg_wdata[CTRL_RUN_BIT];
            end
            if (reg_write && reg_addr == OFS_MEM_MAP)
                mem_owner_map <= reg_wdata;
        end
    end

    // Vector and trigger select tables
    generate
        for (g = 0; g < N_TASKS; g++)
        begin : g_cfg
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    vect_r[g] <= VECT_RST;
                    tsel_r[g] <= TSEL_RST;
                end
                else
                begin
                    if (reg_write && reg_addr == OFS_VECT_BASE + 8'(g))
                        vect_r[g] <= reg_wdata[PC_W-1:0];
                    if (reg_write && reg_addr == OFS_TSEL_BASE + 8'(g))
                        tsel_r[g] <= reg_wdata[TRIG_SEL_W-1:0];
                end
            end
        end
    endgenerate

    // Result, auxiliary and float status registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_RESULT; i++)
                res_r[i] <= '0;
            for (int i = 0; i < NUM_AUX; i++)
                aux_r[i] <= '0;
            fstat_r <= '0;
        end
        else
        begin
            if (res_we)
                res_r[res_sel] <= res_data;
            if (reg_write && in_range(reg_addr, OFS_AUX_BASE, NUM_AUX))
                aux_r[reg_addr[0]] <= reg_wdata[AUX_W-1:0];
            if (reg_write && reg_addr == OFS_FLT_STAT)
                fstat_r <= reg_wdata;
        end
    end

    // Separate buses driven from registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            program_address_bus <= '0;
            read_address_bus    <= '0;
            write_address_bus   <= '0;
            write_data_bus      <= '0;
        end
        else
        begin
            program_address_bus <= pc_r;
            read_address_bus    <= aux_r[0];
            write_address_bus   <= aux_r[1];
            write_data_bus      <= res_r[0];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_read)
        begin
            if (reg_addr == OFS_CTRL)
                reg_rdata <= {30'h0, run_en_r, bg_en_r};
            else if (reg_addr == OFS_STATUS)
                reg_rdata <= {19'h0, cur_r, pend_r, bg_active_r, (state_r != ST_IDLE)};
            else if (reg_addr == OFS_PC)
                reg_rdata <= {16'h0, pc_r};
            else if (reg_addr == OFS_FLT_STAT)
                reg_rdata <= fstat_r;
            else if (reg_addr == OFS_MEM_MAP)
                reg_rdata <= mem_owner_map;
            else if (in_range(reg_addr, OFS_VECT_BASE, N_TASKS))
                reg_rdata <= {16'h0, vect_r[reg_addr[2:0]]};
            else if (in_range(reg_addr, OFS_TSEL_BASE, N_TASKS))
                reg_rdata <= {24'h0, tsel_r[reg_addr[2:0]]};
            else if (in_range(reg_addr, OFS_RES_BASE, NUM_RESULT))
                reg_rdata <= res_r[reg_addr[1:0]];
            else if (in_range(reg_addr, OFS_AUX_BASE, NUM_AUX))
                reg_rdata <= {16'h0, aux_r[reg_addr[0]]};
            else
                reg_rdata <= '0;
        end
        else
            reg_rdata <= '0;
    end

    assign task_running = (state_r == ST_RUN);
    assign active_task  = cur_r;

    accel_fetch_pipe #(
        .STAGES (PIPE_STAGES)
    ) u_pipe (
        .clock   (clock),
        .reset_n (reset_n),
        .flush   (state_r == ST_LOAD),
        .issue   (task_running && exec_issue),
        .busy    (pipe_busy)
    );

    // Checks
    a_load_from_vect: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_LOAD |=> pc_r == $past(vect_r[cur_r]))
        else $error("PC not loaded from vector");
    a_no_nesting: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_RUN && !task_end |=> state_r == ST_RUN && $stable(cur_r))
        else $error("Task changed while running");
    a_done_irq: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_RUN && task_end && !bg_active_r |=> task_done_irq[$past(cur_r)])
        else $error("Missing completion interrupt");
    a_irq_onehot: assert property (@(posedge clock) disable iff (!reset_n)
        $onehot0(task_done_irq))
        else $error("Multiple completion interrupts");
    a_prio_pick: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_IDLE && run_en_r && any_pend |=> cur_r == $past(pick) && start_pulse[cur_r])
        else $error("Wrong task picked");
    a_pend_clear: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_LOAD && !trig_hit[cur_r] |=> !pend_r[$past(cur_r)])
        else $error("Pending not cleared at start");
    a_pend_keep: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_RUN && trig_hit[cur_r] |=> pend_r[$past(cur_r)])
        else $error("Running task trigger lost");
    a_bg_mode: assert property (@(posedge clock) disable iff (!reset_n)
        bg_en_r && !(sw_trig_valid && sw_trig_mask[N_TASKS-1]) |-> !trig_hit[N_TASKS-1])
        else $error("Background task peripheral triggered");
    a_auto_next: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_DONE ##1 (run_en_r && any_pend) |=> state_r == ST_LOAD)
        else $error("Next task not started");

endmodule // accel_task_sequencer_core

`default_nettype wire

// *** dv/accel_exec_model.sv ***
/*
 * Execution unit stand-in: issues while a task runs, ends it after RUN_LEN.
 * Assumes task_running from the sequencer; hold keeps a task going.
 */
`timescale 1ns/1ps
`default_nettype none

module accel_exec_model
    import accel_pkg::*;
#(
    parameter int RUN_LEN = 12
)
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Sequencer side
    input  wire logic task_running,
    input  wire logic hold,
    output logic      task_end,
    output logic      exec_issue
);
    logic [7:0] cnt_r;

    // Run length count, holds at 255
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cnt_r <= 8'h00;
        else if (!task_running || task_end)
            cnt_r <= 8'h00;
        else if (cnt_r != 8'hff)
            cnt_r <= cnt_r + 8'h01;
    end

    // One end pulse per task, issue while running
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            task_end <= 1'b0;
            exec_issue <= 1'b0;
        end
        else
        begin
            task_end <= task_running && !task_end && !hold && cnt_r >= 8'(RUN_LEN - 1);
            exec_issue <= task_running && !task_end;
        end
    end
endmodule // accel_exec_model

`default_nettype wire

// *** dv/test_accel_task_sequencer_core.sv ***
/*
 * Bench for the task sequencer core: register tasks and task sequences.
 * Assumes the execution model ends each task after a fixed run length while hold is low.
 */
`timescale 1ns/1ps
`default_nettype none

module test_accel_task_sequencer_core
    import accel_pkg::*;
;
    logic              clock = 1'b0;
    logic              reset_n = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [255:0]      periph_trig = '0;
    logic              sw_trig_valid = 1'b0;
    logic [7:0]        sw_trig_mask = 8'h00;
    logic              task_end, exec_issue, task_running, pipe_busy;
    logic              hold = 1'b0;
    logic [PC_W-1:0]   program_address_bus, read_address_bus, write_address_bus;
    logic [DATA_W-1:0] write_data_bus, mem_owner_map;
    logic              res_we = 1'b0;
    logic [1:0]        res_sel = 2'h0;
    logic [DATA_W-1:0] res_data = '0;
    logic [7:0]        task_done_irq;
    logic [2:0]        active_task;
    logic              run_q = 1'b0;
    logic              first_q = 1'b0;
    logic [2:0]        launch_q[$], done_q[$];
    logic [15:0]       pc_q[$];
    int                mismatches = 0;
    int                n_checks = 0;
    int                cycles = 0;

    always #10 clock = ~clock;

    accel_task_sequencer_core uut (
        .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .periph_trig, .sw_trig_valid, .sw_trig_mask, .task_end, .exec_issue,
        .program_address_bus, .program_data_bus(32'h0), .read_address_bus,
        .read_data_bus(32'h0), .write_address_bus, .write_data_bus, .res_we,
        .res_sel, .res_data, .task_done_irq, .mem_owner_map, .task_running,
        .active_task, .pipe_busy
    );

    accel_exec_model #(.RUN_LEN(12)) xm (
        .clock, .reset_n, .task_running, .hold, .task_end, .exec_issue
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Launch order, start address and completions
    always @(posedge clock)
    begin
        if (first_q)
        begin
            launch_q.push_back(active_task);
            pc_q.push_back(program_address_bus);
        end
        else if (run_q && task_running && launch_q.size() > 0)
            check("active task", 32'(active_task), 32'(launch_q[$]));
        for (int i = 0; i < 8; i++)
            if (task_done_irq[i] === 1'b1)
                done_q.push_back(3'(i));
        first_q <= task_running && !run_q;
        run_q <= task_running;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        check(what, reg_rdata, exp);
    endtask

    task automatic pulse(input logic [255:0] b);
        @(posedge clock);
        periph_trig <= b;
        @(posedge clock);
        periph_trig <= '0;
    endtask

    function automatic logic [255:0] src(input int i);
        return 256'h1 << ((i == 7) ? 255 : 16 + i);
    endfunction

    function automatic logic [15:0] vec(input int i);
        return 16'h0100 + 16'(i * 16);
    endfunction

    task automatic expect_runs(input logic [2:0] e[3], input int n);
        for (int w = 0; w < 2000 && (done_q.size() < n || task_running !== 1'b0); w++)
            @(posedge clock);
        check("launches", 32'(launch_q.size()), 32'(n));
        check("dones", 32'(done_q.size()), 32'(n));
        for (int k = 0; k < n && k < launch_q.size() && k < done_q.size(); k++)
        begin
            check("task", 32'(launch_q[k]), 32'(e[k]));
            check("start", 32'(pc_q[k]), 32'(vec(e[k])));
            check("irq", 32'(done_q[k]), 32'(e[k]));
        end
        launch_q.delete();
        pc_q.delete();
        done_q.delete();
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        rd_chk(OFS_CTRL, 32'h0, "ctrl");
        rd_chk(OFS_STATUS, 32'h0, "status");
        rd_chk(OFS_PC, 32'h0, "pc");
        rd_chk(OFS_MEM_MAP, MEM_MAP_RST, "mem map");
        rd_chk(8'h30, 32'h0, "unmapped");
        check("irq out", 32'(task_done_irq), 32'h0);
        check("pipe idle", 32'(pipe_busy), 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            rd_chk(OFS_VECT_BASE + 8'(i), 32'(VECT_RST), "vector rst");
            rd_chk(OFS_TSEL_BASE + 8'(i), 32'(TSEL_RST), "tsel rst");
            wr(OFS_VECT_BASE + 8'(i), 32'(vec(i)));
            wr(OFS_TSEL_BASE + 8'(i), (i == 7) ? 32'h0000_00ff : 32'(16 + i));
            rd_chk(OFS_VECT_BASE + 8'(i), 32'(vec(i)), "vector");
        end
        $display("test reset and setup done");
        pulse(src(4));
        pulse(src(2) | src(1));
        pulse(src(2));
        repeat (4) @(posedge clock);
        check("running", 32'(task_running), 32'h0);
        rd_chk(OFS_STATUS, 32'h0000_0058, "pending");
        wr(OFS_CTRL, 32'h0000_0002);
        expect_runs('{3'd1, 3'd2, 3'd4}, 3);
        $display("test priority done");
        pulse(src(3));
        for (int w = 0; w < 50 && task_running !== 1'b1; w++)
            @(posedge clock);
        pulse(src(3) | src(0));
        expect_runs('{3'd3, 3'd0, 3'd3}, 3);
        $display("test no nesting done");
        @(posedge clock);
        sw_trig_valid <= 1'b1;
        sw_trig_mask <= 8'h41;
        @(posedge clock);
        sw_trig_valid <= 1'b0;
        expect_runs('{3'd0, 3'd6, 3'd0}, 2);
        $display("test software trigger done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            res_we <= 1'b1;
            res_sel <= 2'(i);
            res_data <= 32'hc0de_0000 + 32'(i);
        end
        @(posedge clock);
        res_we <= 1'b0;
        wr(OFS_RES_BASE, 32'h1234_5678);
        for (int i = 0; i < 4; i++)
            rd_chk(OFS_RES_BASE + 8'(i), 32'hc0de_0000 + 32'(i), "result");
        check("write data bus", write_data_bus, 32'hc0de_0000);
        wr(OFS_AUX_BASE, 32'h0000_a5a5);
        wr(OFS_AUX_BASE + 8'h01, 32'h0000_5a5a);
        rd_chk(OFS_AUX_BASE + 8'h01, 32'h0000_5a5a, "aux1");
        check("read addr bus", 32'(read_address_bus), 32'h0000_a5a5);
        check("write addr bus", 32'(write_address_bus), 32'h0000_5a5a);
        wr(OFS_MEM_MAP, 32'h0000_00a5);
        wr(8'h30, 32'hffff_ffff);
        rd_chk(OFS_MEM_MAP, 32'h0000_00a5, "mem map");
        check("owner map", mem_owner_map, 32'h0000_00a5);
        rd_chk(8'h30, 32'h0, "unmapped");
        wr(OFS_FLT_STAT, 32'h0000_0f0f);
        rd_chk(OFS_FLT_STAT, 32'h0000_0f0f, "float status");
        $display("test data registers done");
        hold <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0003);
        for (int w = 0; w < 50 && task_running !== 1'b1; w++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        rd_chk(OFS_STATUS, 32'h0000_1c03, "bg status");
        check("pipe busy", 32'(pipe_busy), 32'h1);
        pulse(src(1) | src(7));
        rd_chk(OFS_STATUS, 32'h0000_1c0b, "bg pending");
        repeat (20) @(posedge clock);
        check("bg kept", 32'(active_task), 32'h7);
        hold <= 1'b0;
        for (int w = 0; w < 400 && launch_q.size() < 3; w++)
            @(posedge clock);
        hold <= 1'b1;
        check("bg order", 32'({launch_q[0], launch_q[1], launch_q[2]}), 32'h1cf);
        check("bg irqs", 32'(done_q.size()), 32'h1);
        check("bg irq", 32'(done_q[0]), 32'h1);
        $display("test background done");
        wrap_up();
    end
endmodule // test_accel_task_sequencer_core

`default_nettype wire
